// ===== itc_ctrl.sv
// trap status, interrupt control and request flag registers on apb
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RQ1] nesting disable blocks preemption while in service
// [RQ2] ordinary overflow flags for accumulators A, B
// [RQ3] catastrophic overflow flags for accumulators A, B
// [RQ4] per-accumulator overflow trap enables gate traps
// [RQ5] shared enable gates catastrophic overflow traps
// [RQ6] invalid shift amount sets shift status
// [RQ7] divide by zero sets its status bit
// [RQ8] arithmetic status set on any math trap
// [RQ9] address error trap sets status bit three
// [RQ10] stack error trap sets status bit two
// [RQ11] oscillator failure sets status bit one
// [RQ12] unimplemented bits always read zero
// [RQ13] alternate vector table select bit
// [RQ14] read-only timed disable active status
// [RQ15] polarity bits choose external edge direction
// [RQ16] flags set by sources, software read/write
// [RQ17] upper byte request flag mapping
// [RQ18] lower byte request flag mapping
// [RQ19] all implemented bits zero at reset
// [RQ20] interrupt needs enable and higher priority
// [RQ21] alternate table applies to all exceptions
// [RQ22] sync pins, flag one cycle after edge
module itc_ctrl
  import itc_pkg::*;
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // apb slave
  input  wire logic [11:0]               paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // processor core
  input  wire itc_pkg::itc_trap_evt_s    trap_evt,
  input  wire logic                      timed_irq_disable_active_active,
  input  wire logic [3:0]                cpu_priority_level,
  input  wire logic                      core_in_service,
  output logic                           irq_req,
  output logic      [3:0]                irq_source,
  output logic                           math_trap_req,
  output logic                           alternate_vector_select,
  output logic                           nesting_disable,
  // peripherals and pins
  input  wire itc_pkg::itc_periph_evt_s  periph_evt,
  input  wire logic [2:0]                ext_req_pin,
  output logic      [2:0]                ext_req_edge
);

  itc_state_s  st_r;
  itc_state_s  st_nxt;
  logic [2:0]  edge_hit;
  logic [2:0]  edge_pol;
  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic [15:0] set_c1;
  logic [15:0] set_f0;
  logic [15:0] pend;
  logic [15:0] rd_val;
  logic        ova_hit;
  logic        ovb_hit;
  logic        cova_hit;
  logic        covb_hit;
  logic        math_hit;
  // address decode and write strobes
  logic        hit_ctl1;
  logic        hit_ctl2;
  logic        hit_flag0;
  logic        hit_ena0;
  logic        hit_prio0;
  logic        wr_ctl1;
  logic        wr_ctl2;
  logic        wr_flag0;
  logic        wr_ena0;
  logic        wr_prio0;
  logic [15:0] wr_val;
  // arbitration
  logic        pend_any;
  logic        prio_above;
  logic        nest_block;
  logic        irq_nxt;
  logic [3:0]  src_nxt;

  // ------------------------------------------------------------------
  // external request edge detectors
  // ------------------------------------------------------------------
  assign edge_pol = st_r.ctl2[2:0];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ext
      itc_edge_det u_edge (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .pin        (ext_req_pin[gi]),
        .neg_sel    (edge_pol[gi]),
        .edge_pulse (edge_hit[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  always_comb
  begin
    hit_ctl1  = (paddr == ITC_OFS_CTL1);
    hit_ctl2  = (paddr == ITC_OFS_CTL2);
    hit_flag0 = (paddr == ITC_OFS_FLAG0);
    hit_ena0  = (paddr == ITC_OFS_ENA0);
    hit_prio0 = (paddr == ITC_OFS_PRIO0);
    mapped    = hit_ctl1 | hit_ctl2 | hit_flag0 |
                hit_ena0 | hit_prio0;
  end

  assign wr_en    = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  // ------------------------------------------------------------------
  // write strobes
  // ------------------------------------------------------------------
  // upper half of the bus word is ignored
  assign wr_val   = pwdata[15:0];
  assign wr_ctl1  = wr_en & hit_ctl1;
  assign wr_ctl2  = wr_en & hit_ctl2;
  assign wr_flag0 = wr_en & hit_flag0;
  assign wr_ena0  = wr_en & hit_ena0;
  assign wr_prio0 = wr_en & hit_prio0;

  // ------------------------------------------------------------------
  // trap event qualification
  // ------------------------------------------------------------------
  always_comb
  begin
    // [RQ4] overflow traps need their enable
    ova_hit  = trap_evt.ovf_a & st_r.ctl1[ITC_C1_OVA_TE];
    ovb_hit  = trap_evt.ovf_b & st_r.ctl1[ITC_C1_OVB_TE];
    // [RQ5] one enable for both accumulators
    cova_hit = trap_evt.cat_a & st_r.ctl1[ITC_C1_COV_TE];
    covb_hit = trap_evt.cat_b & st_r.ctl1[ITC_C1_COV_TE];
    math_hit = ova_hit | ovb_hit | cova_hit | covb_hit |
               trap_evt.bad_shift | trap_evt.div_zero;
  end

  // ------------------------------------------------------------------
  // hardware set terms
  // ------------------------------------------------------------------
  always_comb
  begin
    set_c1 = ITC_RST_REG;
    // [RQ2] ordinary overflow flags
    set_c1[ITC_C1_OVA_FLAG]  = ova_hit;
    set_c1[ITC_C1_OVB_FLAG]  = ovb_hit;
    // [RQ3] catastrophic overflow flags
    set_c1[ITC_C1_COVA_FLAG] = cova_hit;
    set_c1[ITC_C1_COVB_FLAG] = covb_hit;
    // [RQ6] invalid shift status
    set_c1[ITC_C1_SHIFT_ERR] = trap_evt.bad_shift;
    // [RQ7] divide by zero status
    set_c1[ITC_C1_DIV0_ERR]  = trap_evt.div_zero;
    // [RQ8] any math trap status
    set_c1[ITC_C1_MATH_ERR]  = math_hit;
    // [RQ9] address error status
    set_c1[ITC_C1_ADDR_ERR]  = trap_evt.addr_fault;
    // [RQ10] stack error status
    set_c1[ITC_C1_STACK_ERR] = trap_evt.stack_fault;
    // [RQ11] oscillator failure status
    set_c1[ITC_C1_OSC_FAIL]  = trap_evt.osc_fail;
  end

  // ------------------------------------------------------------------
  // request flag set terms
  // ------------------------------------------------------------------
  always_comb
  begin
    set_f0 = ITC_RST_REG;
    // [RQ17] upper byte sources
    set_f0[ITC_F0_TW_MASTER] = periph_evt.tw_master;
    set_f0[ITC_F0_TW_SLAVE]  = periph_evt.tw_slave;
    set_f0[ITC_F0_NVM]       = periph_evt.nvm;
    set_f0[ITC_F0_ADC]       = periph_evt.adc;
    set_f0[ITC_F0_SER_TX]    = periph_evt.ser_tx;
    set_f0[ITC_F0_SER_RX]    = periph_evt.ser_rx;
    set_f0[ITC_F0_SPI]       = periph_evt.spi;
    // [RQ18] lower byte sources
    set_f0[ITC_F0_TMR3]      = periph_evt.tmr3;
    set_f0[ITC_F0_TMR2]      = periph_evt.tmr2;
    set_f0[ITC_F0_CMP2]      = periph_evt.cmp2;
    set_f0[ITC_F0_TMR1]      = periph_evt.tmr1;
    set_f0[ITC_F0_CMP1]      = periph_evt.cmp1;
    set_f0[ITC_F0_CAP1]      = periph_evt.cap1;
    // [RQ22] flag set after detected edge
    set_f0[ITC_F0_EXT0]      = edge_hit[0];
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb
  begin
    rd_val = ITC_RST_REG;
    unique case (paddr)
      ITC_OFS_CTL1:  rd_val = st_r.ctl1;
      ITC_OFS_CTL2:  rd_val = st_r.ctl2;
      ITC_OFS_FLAG0: rd_val = st_r.flag0;
      ITC_OFS_ENA0:  rd_val = st_r.ena0;
      ITC_OFS_PRIO0: rd_val = st_r.prio0;
      default:       rd_val = ITC_RST_REG;
    endcase
  end

  // ------------------------------------------------------------------
  // pending request arbitration
  // ------------------------------------------------------------------
  assign pend = st_r.flag0 & st_r.ena0;

  always_comb
  begin
    pend_any   = |pend;
    // [RQ20] request level above core level
    prio_above = ({1'b0, st_r.prio0[2:0]} > cpu_priority_level);
    // [RQ1] no preemption while nesting disabled
    nest_block = st_r.ctl1[ITC_C1_NEST_DIS] & core_in_service;
    irq_nxt    = pend_any & prio_above & ~nest_block;
    // lowest pending bit names the source
    src_nxt    = ITC_RST_SRC;
    for (int i = 15; i >= 0; i--)
    begin
      if (pend[i])
        src_nxt = 4'(i);
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;

    // [RQ16] software write then sources set
    if (wr_ctl1)
    begin
      st_nxt.ctl1 = wr_val & ITC_C1_WMASK;
    end
    if (wr_ctl2)
    begin
      st_nxt.ctl2 = wr_val & ITC_C2_WMASK;
    end
    if (wr_flag0)
    begin
      st_nxt.flag0 = wr_val & ITC_F0_WMASK;
    end
    if (wr_ena0)
    begin
      st_nxt.ena0 = wr_val & ITC_F0_WMASK;
    end
    if (wr_prio0)
    begin
      st_nxt.prio0 = wr_val & ITC_PRIO_WMASK;
    end

    // set wins over a clearing write
    st_nxt.ctl1  = st_nxt.ctl1 | set_c1;
    // [RQ16] request flags are sticky
    st_nxt.flag0 = st_nxt.flag0 | set_f0;

    // [RQ14] timed disable status, read only
    st_nxt.ctl2[ITC_C2_TIMED_IRQ_DISABLE_ACTIVE] = timed_irq_disable_active_active;

    // [RQ12] unimplemented positions forced low
    st_nxt.ctl1  = st_nxt.ctl1 & ITC_C1_WMASK;
    st_nxt.ctl2  = st_nxt.ctl2 &
                   (ITC_C2_WMASK | (16'h0001 << ITC_C2_TIMED_IRQ_DISABLE_ACTIVE));
    st_nxt.flag0 = st_nxt.flag0 & ITC_F0_WMASK;

    // read data captured in setup, shown in access
    if (rd_setup)
      st_nxt.rdata = {16'h0000, rd_val};

    // math trap request toward the core
    st_nxt.math_trap = math_hit;

    // [RQ20] enable and priority above core level
    st_nxt.irq = irq_nxt;
    st_nxt.src = src_nxt;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      // [RQ19] all implemented bits clear
      st_r.ctl1      <= ITC_RST_REG;
      st_r.ctl2      <= ITC_RST_REG;
      st_r.flag0     <= ITC_RST_REG;
      st_r.ena0      <= ITC_RST_REG;
      st_r.prio0     <= ITC_RST_REG;
      st_r.rdata     <= 32'h0000_0000;
      st_r.irq       <= 1'b0;
      st_r.src       <= ITC_RST_SRC;
      st_r.math_trap <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata        = st_r.rdata;
  // no wait states
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & ~mapped;

  // ------------------------------------------------------------------
  // core outputs
  // ------------------------------------------------------------------
  assign irq_req       = st_r.irq;
  assign irq_source    = st_r.src;
  assign math_trap_req = st_r.math_trap;
  assign ext_req_edge  = edge_hit;
  assign nesting_disable = st_r.ctl1[ITC_C1_NEST_DIS];

  // [RQ13] vector table choice to core
  // [RQ21] one select for every exception
  assign alternate_vector_select = st_r.ctl2[ITC_C2_ALT_VEC];

endmodule : itc_ctrl

`default_nettype wire

// ===== itc_pkg.sv
// constants, event carriers and state types for the trap/interrupt block
package itc_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] ITC_OFS_CTL1  = 12'h000;
  localparam logic [11:0] ITC_OFS_CTL2  = 12'h004;
  localparam logic [11:0] ITC_OFS_FLAG0 = 12'h008;
  localparam logic [11:0] ITC_OFS_ENA0  = 12'h00C;
  localparam logic [11:0] ITC_OFS_PRIO0 = 12'h010;

  // ------------------------------------------------------------------
  // first control register fields
  // ------------------------------------------------------------------
  localparam int ITC_C1_NEST_DIS  = 15;
  localparam int ITC_C1_OVA_FLAG  = 14;
  localparam int ITC_C1_OVB_FLAG  = 13;
  localparam int ITC_C1_COVA_FLAG = 12;
  localparam int ITC_C1_COVB_FLAG = 11;
  localparam int ITC_C1_OVA_TE    = 10;
  localparam int ITC_C1_OVB_TE    = 9;
  localparam int ITC_C1_COV_TE    = 8;
  localparam int ITC_C1_SHIFT_ERR = 7;
  localparam int ITC_C1_DIV0_ERR  = 6;
  localparam int ITC_C1_MATH_ERR  = 4;
  localparam int ITC_C1_ADDR_ERR  = 3;
  localparam int ITC_C1_STACK_ERR = 2;
  localparam int ITC_C1_OSC_FAIL  = 1;
  localparam logic [15:0] ITC_C1_WMASK = 16'hFFDE;

  // ------------------------------------------------------------------
  // second control register fields
  // ------------------------------------------------------------------
  localparam int ITC_C2_ALT_VEC   = 15;
  localparam int ITC_C2_TIMED_IRQ_DISABLE_ACTIVE      = 14;
  localparam logic [15:0] ITC_C2_WMASK = 16'h8007;

  // ------------------------------------------------------------------
  // flag register fields
  // ------------------------------------------------------------------
  localparam int ITC_F0_TW_MASTER = 14;
  localparam int ITC_F0_TW_SLAVE  = 13;
  localparam int ITC_F0_NVM       = 12;
  localparam int ITC_F0_ADC       = 11;
  localparam int ITC_F0_SER_TX    = 10;
  localparam int ITC_F0_SER_RX    = 9;
  localparam int ITC_F0_SPI       = 8;
  localparam int ITC_F0_TMR3      = 7;
  localparam int ITC_F0_TMR2      = 6;
  localparam int ITC_F0_CMP2      = 5;
  localparam int ITC_F0_TMR1      = 3;
  localparam int ITC_F0_CMP1      = 2;
  localparam int ITC_F0_CAP1      = 1;
  localparam int ITC_F0_EXT0      = 0;
  localparam logic [15:0] ITC_F0_WMASK = 16'h7FEF;
  localparam logic [15:0] ITC_PRIO_WMASK = 16'h0007;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] ITC_RST_REG  = 16'h0000;
  localparam logic [3:0]  ITC_RST_SRC  = 4'h0;
  localparam logic [1:0]  ITC_RST_SYNC = 2'h0;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic ovf_a;
    logic ovf_b;
    logic cat_a;
    logic cat_b;
    logic bad_shift;
    logic div_zero;
    logic addr_fault;
    logic stack_fault;
    logic osc_fail;
  } itc_trap_evt_s;

  typedef struct packed {
    logic tw_master;
    logic tw_slave;
    logic nvm;
    logic adc;
    logic ser_tx;
    logic ser_rx;
    logic spi;
    logic tmr3;
    logic tmr2;
    logic cmp2;
    logic tmr1;
    logic cmp1;
    logic cap1;
  } itc_periph_evt_s;

  // ------------------------------------------------------------------
  // module state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync;
    logic       prev;
    logic       armed;
    logic       pulse;
  } itc_edge_state_s;

  typedef struct packed {
    logic [15:0] ctl1;
    logic [15:0] ctl2;
    logic [15:0] flag0;
    logic [15:0] ena0;
    logic [15:0] prio0;
    logic [31:0] rdata;
    logic        irq;
    logic [3:0]  src;
    logic        math_trap;
  } itc_state_s;

endpackage : itc_pkg

// ===== itc_edge_det.sv
// synchroniser and selectable edge detector for one external request pin
`timescale 1ns/1ps
`default_nettype none

module itc_edge_det
  import itc_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // pin and polarity
  input  wire logic pin,
  input  wire logic neg_sel,
  // detected edge
  output logic      edge_pulse
);

  itc_edge_state_s st_r;
  itc_edge_state_s st_nxt;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt       = st_r;
    // [RQ22] two-stage synchroniser
    st_nxt.sync  = {st_r.sync[0], pin};
    st_nxt.prev  = st_r.sync[1];
    st_nxt.armed = 1'b1;
    // [RQ15] polarity selects edge
    if (neg_sel)
      st_nxt.pulse = st_r.armed & st_r.prev & ~st_r.sync[1];
    else
      st_nxt.pulse = st_r.armed & ~st_r.prev & st_r.sync[1];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_r.sync  <= ITC_RST_SYNC;
      st_r.prev  <= 1'b0;
      st_r.armed <= 1'b0;
      st_r.pulse <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign edge_pulse = st_r.pulse;

endmodule : itc_edge_det

`default_nettype wire

// ===== itc_ctrl_asserts.sv
// port-level checks for the trap and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module itc_ctrl_asserts
  import itc_pkg::*;
(
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_n,
  // apb
  input wire logic [11:0]            paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  // core and pins
  input wire itc_pkg::itc_trap_evt_s trap_evt,
  input wire logic [3:0]             cpu_priority_level,
  input wire logic                   core_in_service,
  input wire logic                   irq_req,
  input wire logic                   math_trap_req,
  input wire logic                   alternate_vector_select,
  input wire logic                   nesting_disable,
  input wire logic [2:0]             ext_req_pin,
  input wire logic [2:0]             ext_req_edge
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  AST_NEST_HOLD: assert property (
    nesting_disable && core_in_service |=> !irq_req)
    else $error("irq raised while nesting blocked");
  AST_PRIO_LOW: assert property (
    cpu_priority_level >= 4'h7 |=> !irq_req)
    else $error("irq raised at top core level");
  AST_MATH_SET: assert property (
    trap_evt.bad_shift || trap_evt.div_zero |=> math_trap_req)
    else $error("math trap missing");
  AST_MATH_CAUSE: assert property (
    math_trap_req |-> $past(trap_evt[8:3]) != 6'h00)
    else $error("math trap without cause");
  AST_ALT_WR: assert property (
    wr_acc && paddr == ITC_OFS_CTL2
    |=> alternate_vector_select == $past(pwdata[15]))
    else $error("vector select not written");
  AST_NEST_WR: assert property (
    wr_acc && paddr == ITC_OFS_CTL1
    |=> nesting_disable == $past(pwdata[15]))
    else $error("nesting disable not written");
  AST_UNIMPL: assert property (
    rd_acc |-> !(paddr == ITC_OFS_CTL1 && (prdata[5] || prdata[0]))
    && !(paddr == ITC_OFS_CTL2 && prdata[13:3] != 11'h000)
    && !(paddr == ITC_OFS_FLAG0 && (prdata[15] || prdata[4])))
    else $error("unimplemented bit read as one");
  AST_EDGE_CAUSE: assert property (
    ext_req_edge != 3'h0 |-> (ext_req_edge
    & ~($past(ext_req_pin, 2) ^ $past(ext_req_pin, 6))) == 3'h0)
    else $error("edge pulse without pin change");
  AST_EDGE_PULSE: assert property (
    ext_req_edge[0] |=> !ext_req_edge[0])
    else $error("edge pulse too long");
  cover property (irq_req);
  cover property (math_trap_req);
  cover property (ext_req_edge[0]);
endmodule : itc_ctrl_asserts
`default_nettype wire

// ===== itc_core_model.sv
// core, peripheral and pin side model
`timescale 1ns/1ps
`default_nettype none
module itc_core_model
  import itc_pkg::*;
(
  input  wire logic                    mclk,
  output var itc_pkg::itc_trap_evt_s   trap_evt,
  output var itc_pkg::itc_periph_evt_s periph_evt,
  output var logic [2:0]               ext_req_pin,
  output var logic                     timed_irq_disable_active_active,
  output var logic [3:0]               cpu_priority_level,
  output var logic                     core_in_service
);
  initial
  begin
    trap_evt = '0;
    periph_evt = '0;
    ext_req_pin = 3'h0;
    timed_irq_disable_active_active = 1'b0;
    cpu_priority_level = 4'h0;
    core_in_service = 1'b0;
  end
  task pulse_trap(input logic [8:0] v);
    @(posedge mclk);
    trap_evt <= v;
    @(posedge mclk);
    trap_evt <= '0;
  endtask : pulse_trap
  task pulse_periph(input logic [12:0] v);
    @(posedge mclk);
    periph_evt <= v;
    @(posedge mclk);
    periph_evt <= '0;
  endtask : pulse_periph
  task set_pin(input int i, input logic v);
    @(posedge mclk);
    ext_req_pin[i] <= v;
  endtask : set_pin
  task set_core(input logic d, input logic [3:0] l, input logic s);
    @(posedge mclk);
    timed_irq_disable_active_active <= d;
    cpu_priority_level <= l;
    core_in_service <= s;
  endtask : set_core
endmodule : itc_core_model
`default_nettype wire

// ===== itc_ctrl_tb.sv
// self-checking bench for the trap and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module itc_ctrl_tb;
  import itc_pkg::*;
  logic                    mclk, rst_n, psel, penable, pwrite, pready;
  logic                    pslverr, timed_irq_disable_active_active, core_in_service, irq_req;
  logic                    math_trap_req, alternate_vector_select;
  logic                    nesting_disable, err;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd, c1, c2;
  logic [3:0]              cpu_priority_level, irq_source;
  logic [2:0]              ext_req_pin, ext_req_edge;
  itc_pkg::itc_trap_evt_s   trap_evt;
  itc_pkg::itc_periph_evt_s periph_evt;
  int                      miscompares, check_count;
  logic [11:0] ofs[3] = '{ITC_OFS_CTL1, ITC_OFS_CTL2, ITC_OFS_FLAG0};
  logic [15:0] msk[3] = '{16'hFFDE, 16'h8007, 16'h7FEF};
  logic [15:0] tev[9] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810,
                          16'h0090, 16'h0050, 16'h0008, 16'h0004, 16'h0002};
  int          pb[13] = '{14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 3, 2, 1};

  itc_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trap_evt(trap_evt),
    .timed_irq_disable_active_active(timed_irq_disable_active_active), .cpu_priority_level(cpu_priority_level),
    .core_in_service(core_in_service), .irq_req(irq_req),
    .irq_source(irq_source), .math_trap_req(math_trap_req),
    .alternate_vector_select(alternate_vector_select),
    .nesting_disable(nesting_disable), .periph_evt(periph_evt),
    .ext_req_pin(ext_req_pin), .ext_req_edge(ext_req_edge));
  itc_core_model i_core (.mclk(mclk), .trap_evt(trap_evt),
    .periph_evt(periph_evt), .ext_req_pin(ext_req_pin),
    .timed_irq_disable_active_active(timed_irq_disable_active_active), .cpu_priority_level(cpu_priority_level),
    .core_in_service(core_in_service));

  always #5 mclk = ~mclk;
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic [11:0] a, input logic w, input logic [15:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [11:0] a, input logic [15:0] exp);
    apb(a, 1'b0, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask : rd_chk
  task edge_cnt(input int i, input logic v, output logic [31:0] c);
    i_core.set_pin(i, v);
    c = 32'h0;
    repeat (10)
    begin
      @(negedge mclk);
      if (ext_req_edge[i] === 1'b1) c++;
    end
  endtask : edge_cnt
  task final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rd_chk(ofs[i], 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      apb(ofs[i], 1'b1, 16'hFFFF);
      rd_chk(ofs[i], msk[i]);
    end
    chk({31'h0, alternate_vector_select}, 32'h1);
    chk({31'h0, nesting_disable}, 32'h1);
    for (int i = 0; i < 3; i++) apb(ofs[i], 1'b1, 16'h0000);
    for (int i = 0; i < 3; i++) rd_chk(ofs[i], 16'h0000);
    apb(12'h020, 1'b1, 16'hFFFF);
    apb(12'h020, 1'b0, 16'h0000);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test registers finished");
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 9; i++)
      begin
        apb(ITC_OFS_CTL1, 1'b1, e ? 16'h0700 : 16'h0000);
        i_core.pulse_trap(9'h100 >> i);
        @(negedge mclk);
        chk({31'h0, math_trap_req}, (i < 4) ? e : (i < 6));
        rd_chk(ITC_OFS_CTL1,
               e ? (tev[i] | 16'h0700) : (i < 4 ? 16'h0 : tev[i]));
      end
    apb(ITC_OFS_CTL1, 1'b1, 16'h0000);
    $display("test traps finished");
    for (int i = 0; i < 13; i++)
    begin
      i_core.pulse_periph(13'h1000 >> i);
      rd_chk(ITC_OFS_FLAG0, 16'h0001 << pb[i]);
      apb(ITC_OFS_FLAG0, 1'b1, 16'h0000);
    end
    $display("test flags finished");
    for (int i = 0; i < 3; i++)
      for (int p = 0; p < 2; p++)
      begin
        apb(ITC_OFS_CTL2, 1'b1, p ? (16'h0001 << i) : 16'h0000);
        edge_cnt(i, 1'b1, c1);
        edge_cnt(i, 1'b0, c2);
        chk(c1, p ? 32'h0 : 32'h1);
        chk(c2, p ? 32'h1 : 32'h0);
        if (i == 0) rd_chk(ITC_OFS_FLAG0, 16'h0001);
        apb(ITC_OFS_FLAG0, 1'b1, 16'h0000);
      end
    $display("test pins finished");
    i_core.set_core(1'b1, 4'h0, 1'b0);
    apb(ITC_OFS_CTL2, 1'b1, 16'h0000);
    rd_chk(ITC_OFS_CTL2, 16'h4000);
    i_core.set_core(1'b0, 4'h0, 1'b0);
    rd_chk(ITC_OFS_CTL2, 16'h0000);
    apb(ITC_OFS_ENA0, 1'b1, 16'h0008);
    apb(ITC_OFS_PRIO0, 1'b1, 16'h0005);
    i_core.set_core(1'b0, 4'h4, 1'b0);
    i_core.pulse_periph(13'h0004);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq_req}, 32'h1);
    chk({28'h0, irq_source}, 32'h3);
    i_core.set_core(1'b0, 4'h7, 1'b0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq_req}, 32'h0);
    i_core.set_core(1'b0, 4'h4, 1'b1);
    apb(ITC_OFS_CTL1, 1'b1, 16'h8000);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq_req}, 32'h0);
    i_core.set_core(1'b0, 4'h4, 1'b0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq_req}, 32'h1);
    apb(ITC_OFS_ENA0, 1'b1, 16'h0000);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq_req}, 32'h0);
    $display("test irq finished");
    final_report;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    final_report;
  end
endmodule : itc_ctrl_tb
bind itc_ctrl itc_ctrl_asserts i_chk (.mclk(mclk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .trap_evt(trap_evt),
  .cpu_priority_level(cpu_priority_level),
  .core_in_service(core_in_service), .irq_req(irq_req),
  .math_trap_req(math_trap_req),
  .alternate_vector_select(alternate_vector_select),
  .nesting_disable(nesting_disable), .ext_req_pin(ext_req_pin),
  .ext_req_edge(ext_req_edge));
`default_nettype wire
